// [include/vfc_pkg.sv]
// Constants, field layout and timing for the video filter control block.
// Assumes a single 200 MHz clock; pulse times are converted to cycles here.
package vfc_pkg;

    // ---------------------------------------------------------------
    // Control register layout
    // ---------------------------------------------------------------
    localparam int         CTRL_W          = 8;
    localparam logic [7:0] CTRL_RESET      = 8'h60;
    localparam int         BIT_SYNC_DIR    = 7;
    localparam int         BIT_INPUT       = 6;
    localparam int         BIT_FILTER      = 5;
    localparam int         BIT_CLAMP       = 4;
    localparam int         BIT_GAIN_HI     = 3;
    localparam int         BIT_GAIN_LO     = 2;
    localparam int         BIT_MUTE        = 1;
    localparam int         BIT_SPARE       = 0;

    // ---------------------------------------------------------------
    // Frame layout: broadcast flag, 4 address bits, 8 data bits, LSB first
    // ---------------------------------------------------------------
    localparam int         ADDR_W          = 4;
    localparam logic [3:0] ADDR_MAX        = 4'hF;
    localparam int         FRAME_BITS      = 1 + ADDR_W + CTRL_W;
    localparam int         POS_BCAST       = 0;
    localparam int         POS_ADDR        = 1;
    localparam int         POS_DATA        = POS_ADDR + ADDR_W;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ        = 200;
    localparam int ZERO_MIN_NS    = 1000;
    localparam int ZERO_MAX_NS    = 8000;
    localparam int ONE_MIN_NS     = 24000;
    localparam int ONE_MAX_NS     = 36000;
    localparam int TRANS_MIN_NS   = 80000;
    localparam int TRANS_MAX_NS   = 120000;
    localparam int WAIT_MIN_NS    = 500;
    localparam int ADDR_SLOT_NS   = 1000000;
    localparam int TRIM_PERIOD_NS = 1000;

    // Least times round up, longest times round down
    localparam int ZERO_MIN_CYC    = (ZERO_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int ZERO_MAX_CYC    = (ZERO_MAX_NS * CLK_MHZ) / 1000;
    localparam int ONE_MIN_CYC     = (ONE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int ONE_MAX_CYC     = (ONE_MAX_NS * CLK_MHZ) / 1000;
    localparam int TRANS_MIN_CYC   = (TRANS_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int TRANS_MAX_CYC   = (TRANS_MAX_NS * CLK_MHZ) / 1000;
    localparam int WAIT_MIN_CYC    = (WAIT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int ADDR_SLOT_CYC   = (ADDR_SLOT_NS * CLK_MHZ) / 1000;
    localparam int TRIM_PERIOD_CYC = (TRIM_PERIOD_NS * CLK_MHZ) / 1000;

    localparam int         CNT_W     = 16;
    localparam int         GAP_W     = 8;
    localparam int         SLOT_W    = 20;
    localparam int         TRIM_W    = 4;
    localparam logic [3:0] TRIM_MID  = 4'h8;

    typedef enum logic [1:0] {
        VFC_PULSE_ZERO  = 2'b00,
        VFC_PULSE_ONE   = 2'b01,
        VFC_PULSE_TRANS = 2'b10,
        VFC_PULSE_RESET = 2'b11
    } vfc_pulse_t;

    typedef enum logic [0:0] {
        VFC_ST_IDLE  = 1'b0,
        VFC_ST_FRAME = 1'b1
    } vfc_state_t;

endpackage

// [include/vfc_pulse_if.sv]
// Carrier for classified bus pulses between the meter and the control logic.
// Assumes both ends share one clock; valid is a one-cycle pulse.
`timescale 1ns/1ps
interface vfc_pulse_if;
    import vfc_pkg::*;
    logic       valid;
    vfc_pulse_t kind;
    modport meas (output valid, output kind);
    modport ctrl (input valid, input kind);
endinterface

// [design/vfc_pulse_meas.sv]
// Measures low pulses on the bus data pin and classifies them by width.
// Assumes the pin is asynchronous; it is synchronised here before use.
`timescale 1ns/1ps
module vfc_pulse_meas #(
    parameter int ZERO_MIN  = vfc_pkg::ZERO_MIN_CYC,
    parameter int ZERO_MAX  = vfc_pkg::ZERO_MAX_CYC,
    parameter int ONE_MIN   = vfc_pkg::ONE_MIN_CYC,
    parameter int ONE_MAX   = vfc_pkg::ONE_MAX_CYC,
    parameter int TRANS_MIN = vfc_pkg::TRANS_MIN_CYC,
    parameter int TRANS_MAX = vfc_pkg::TRANS_MAX_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_data,
    vfc_pulse_if.meas pulse
);
    import vfc_pkg::*;

    logic [1:0]       data_sync_r;
    logic             data_prev_r;
    logic [CNT_W-1:0] low_cnt_r;
    logic [GAP_W-1:0] gap_cnt_r;
    logic             gap_ok_r;
    logic             low_end;

    // ---------------------------------------------------------------
    // Pin synchroniser
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            data_sync_r <= 2'h3;
            data_prev_r <= 1'b1;
        end else begin
            data_sync_r <= {data_sync_r[0], i_data};
            data_prev_r <= data_sync_r[1];
        end
    end

    assign low_end = !data_prev_r && data_sync_r[1];

    // ---------------------------------------------------------------
    // Width counters
    // ---------------------------------------------------------------
    // Active low: count while the line is held low, saturating
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_cnt_r <= '0;
        end else if (data_sync_r[1]) begin
            low_cnt_r <= '0;
        end else if (low_cnt_r != '1) begin
            low_cnt_r <= low_cnt_r + CNT_W'(1);
        end
    end

    // A pulse following a too-short gap is treated as noise
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap_cnt_r <= '1;
            gap_ok_r  <= 1'b1;
        end else if (!data_sync_r[1]) begin
            gap_cnt_r <= '0;
            if (data_prev_r) begin
                gap_ok_r <= (32'(gap_cnt_r) >= WAIT_MIN_CYC);
            end
        end else if (gap_cnt_r != '1) begin
            gap_cnt_r <= gap_cnt_r + GAP_W'(1);
        end
    end

    // ---------------------------------------------------------------
    // Classification on the rising edge
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pulse.valid <= 1'b0;
            pulse.kind  <= VFC_PULSE_ZERO;
        end else begin
            pulse.valid <= 1'b0;
            if (low_end && gap_ok_r) begin
                if (32'(low_cnt_r) >= ZERO_MIN && 32'(low_cnt_r) <= ZERO_MAX) begin
                    pulse.valid <= 1'b1;
                    pulse.kind  <= VFC_PULSE_ZERO;
                end else if (32'(low_cnt_r) >= ONE_MIN && 32'(low_cnt_r) <= ONE_MAX) begin
                    pulse.valid <= 1'b1;
                    pulse.kind  <= VFC_PULSE_ONE;
                end else if (32'(low_cnt_r) >= TRANS_MIN
                             && 32'(low_cnt_r) <= TRANS_MAX) begin
                    pulse.valid <= 1'b1;
                    pulse.kind  <= VFC_PULSE_TRANS;
                end else if (32'(low_cnt_r) > TRANS_MAX) begin
                    // Longer than any command: soft reset
                    pulse.valid <= 1'b1;
                    pulse.kind  <= VFC_PULSE_RESET;
                end
            end
        end
    end

endmodule

// [design/vfc_ctrl.sv]
// Channel control register of the video filter, written over the one-wire bus.
// Assumes analog comparators for sync, bias timing and trim feed asynchronous inputs.
`timescale 1ns/1ps
module vfc_ctrl #(
    parameter int ONE_MIN_CYC   = vfc_pkg::ONE_MIN_CYC,
    parameter int ONE_MAX_CYC   = vfc_pkg::ONE_MAX_CYC,
    parameter int TRANS_MIN_CYC = vfc_pkg::TRANS_MIN_CYC,
    parameter int TRANS_MAX_CYC = vfc_pkg::TRANS_MAX_CYC,
    parameter int ADDR_SLOT_CYC = vfc_pkg::ADDR_SLOT_CYC
) (
    input  wire logic                      i_clk,
    input  wire logic                      i_rst_n,
    input  wire logic                      i_data,
    input  wire logic                      i_bias_timing_pin,
    input  wire logic                      i_sync_pin_i,
    input  wire logic                      i_sync_detect,
    input  wire logic                      i_trim_high,
    output logic                           o_sync_pin_o,
    output logic                           o_sync_pin_oe,
    output logic                           o_sync_ext,
    output logic                           o_input_choice,
    output logic                           o_filter_on,
    output logic                           o_clamp_level_select,
    output logic [1:0]                     o_hf_gain,
    output logic                           o_output_mute,
    output logic [vfc_pkg::ADDR_W-1:0]     o_dev_addr,
    output logic                           o_addr_locked,
    output logic [vfc_pkg::TRIM_W-1:0]     o_trim_code,
    output logic [vfc_pkg::CTRL_W-1:0]     o_channel_control
);
    import vfc_pkg::*;

    vfc_pulse_if pulse ();

    vfc_pulse_meas #(
        .ZERO_MIN  (ZERO_MIN_CYC),
        .ZERO_MAX  (ZERO_MAX_CYC),
        .ONE_MIN   (ONE_MIN_CYC),
        .ONE_MAX   (ONE_MAX_CYC),
        .TRANS_MIN (TRANS_MIN_CYC),
        .TRANS_MAX (TRANS_MAX_CYC)
    ) u_meas (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_data  (i_data),
        .pulse   (pulse)
    );

    vfc_state_t            state_r;
    logic [FRAME_BITS-1:0] shift_r;
    logic [3:0]            bit_cnt_r;
    logic [CTRL_W-1:0]     channel_control_r;
    logic                  soft_rst;
    logic                  frame_done;
    logic [FRAME_BITS-1:0] frame;
    logic [1:0]            bias_sync_r;
    logic [1:0]            sync_pin_sync_r;
    logic [1:0]            sync_det_sync_r;
    logic [1:0]            trim_sync_r;
    logic [SLOT_W-1:0]     slot_cnt_r;
    logic [ADDR_W-1:0]     addr_r;
    logic                  locked_r;
    logic [7:0]            trim_cnt_r;
    logic [TRIM_W-1:0]     trim_r;

    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bias_sync_r     <= 2'h0;
            sync_pin_sync_r <= 2'h0;
            sync_det_sync_r <= 2'h0;
            trim_sync_r     <= 2'h0;
        end else begin
            bias_sync_r     <= {bias_sync_r[0], i_bias_timing_pin};
            sync_pin_sync_r <= {sync_pin_sync_r[0], i_sync_pin_i};
            sync_det_sync_r <= {sync_det_sync_r[0], i_sync_detect};
            trim_sync_r     <= {trim_sync_r[0], i_trim_high};
        end
    end

    assign soft_rst = pulse.valid && pulse.kind == VFC_PULSE_RESET;

    // ---------------------------------------------------------------
    // Frame receiver
    // ---------------------------------------------------------------
    // Last bit of the frame lands this cycle
    assign frame_done = state_r == VFC_ST_FRAME && pulse.valid
                        && (pulse.kind == VFC_PULSE_ZERO || pulse.kind == VFC_PULSE_ONE)
                        && bit_cnt_r == 4'(FRAME_BITS - 1);
    // Bits arrive LSB first, so each new bit enters at the top
    assign frame = {pulse.kind == VFC_PULSE_ONE, shift_r[FRAME_BITS-1:1]};

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r   <= VFC_ST_IDLE;
            shift_r   <= '0;
            bit_cnt_r <= 4'h0;
        end else if (pulse.valid) begin
            unique case (pulse.kind)
                VFC_PULSE_TRANS: begin
                    // A command pulse always opens a fresh frame
                    state_r   <= VFC_ST_FRAME;
                    bit_cnt_r <= 4'h0;
                end
                VFC_PULSE_RESET: begin
                    state_r   <= VFC_ST_IDLE;
                    bit_cnt_r <= 4'h0;
                end
                VFC_PULSE_ZERO, VFC_PULSE_ONE: begin
                    if (state_r == VFC_ST_FRAME) begin
                        shift_r   <= frame;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (frame_done) begin
                            state_r <= VFC_ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    // Broadcast always taken; addressed write only once an address is held
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            channel_control_r <= CTRL_RESET;
        end else if (soft_rst) begin
            channel_control_r <= CTRL_RESET;
        end else if (frame_done && (frame[POS_BCAST]
                     || (locked_r && frame[POS_ADDR +: ADDR_W] == addr_r))) begin
            channel_control_r            <= frame[POS_DATA +: CTRL_W];
            channel_control_r[BIT_SPARE] <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Address assignment from the bias pin time constant
    // ---------------------------------------------------------------
    // Slots elapse while the capacitor charges; a larger capacitor gives a
    // higher address. Saturates at the last address rather than wrapping.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slot_cnt_r <= '0;
            addr_r     <= '0;
            locked_r   <= 1'b0;
        end else if (soft_rst) begin
            slot_cnt_r <= '0;
            addr_r     <= '0;
            locked_r   <= 1'b0;
        end else if (!locked_r) begin
            if (bias_sync_r[1]) begin
                locked_r <= 1'b1;
            end else if (32'(slot_cnt_r) >= ADDR_SLOT_CYC - 1) begin
                slot_cnt_r <= '0;
                if (addr_r != ADDR_MAX) begin
                    addr_r <= addr_r + 4'h1;
                end
            end else begin
                slot_cnt_r <= slot_cnt_r + SLOT_W'(1);
            end
        end
    end

    // ---------------------------------------------------------------
    // Corner-frequency trim
    // ---------------------------------------------------------------
    // Steps one code per period, toward the comparator's verdict
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            trim_cnt_r <= 8'h00;
            trim_r     <= TRIM_MID;
        end else if (32'(trim_cnt_r) >= TRIM_PERIOD_CYC - 1) begin
            trim_cnt_r <= 8'h00;
            if (trim_sync_r[1] && trim_r != '0) begin
                trim_r <= trim_r - TRIM_W'(1);
            end else if (!trim_sync_r[1] && trim_r != '1) begin
                trim_r <= trim_r + TRIM_W'(1);
            end
        end else begin
            trim_cnt_r <= trim_cnt_r + 8'h01;
        end
    end

    // ---------------------------------------------------------------
    // Registered outputs
    // ---------------------------------------------------------------
    // One cycle behind the register, so every output comes from a flip-flop
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sync_pin_oe        <= 1'b1;
            o_sync_pin_o         <= 1'b0;
            o_sync_ext           <= 1'b0;
            o_input_choice       <= CTRL_RESET[BIT_INPUT];
            o_filter_on          <= CTRL_RESET[BIT_FILTER];
            o_clamp_level_select <= CTRL_RESET[BIT_CLAMP];
            o_hf_gain            <= CTRL_RESET[BIT_GAIN_HI:BIT_GAIN_LO];
            o_output_mute        <= CTRL_RESET[BIT_MUTE];
            o_dev_addr           <= '0;
            o_addr_locked        <= 1'b0;
            o_trim_code          <= TRIM_MID;
            o_channel_control    <= CTRL_RESET;
        end else begin
            o_sync_pin_oe        <= !channel_control_r[BIT_SYNC_DIR];
            o_sync_pin_o         <= sync_det_sync_r[1];
            // External sync only heard while the pin is an input
            o_sync_ext           <= channel_control_r[BIT_SYNC_DIR]
                                    && sync_pin_sync_r[1];
            o_input_choice       <= channel_control_r[BIT_INPUT];
            o_filter_on          <= channel_control_r[BIT_FILTER];
            o_clamp_level_select <= channel_control_r[BIT_CLAMP];
            o_hf_gain            <= channel_control_r[BIT_GAIN_HI:BIT_GAIN_LO];
            o_output_mute        <= channel_control_r[BIT_MUTE];
            o_dev_addr           <= addr_r;
            o_addr_locked        <= locked_r;
            o_trim_code          <= trim_r;
            o_channel_control    <= channel_control_r;
        end
    end

endmodule

// [dv/vfc_ctrl_chk.sv]
// Assertions on the control register block, seen from its ports only.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
module vfc_ctrl_chk
    import vfc_pkg::*;
(
    input wire logic                       i_clk,
    input wire logic                       i_rst_n,
    input wire logic                       o_sync_pin_oe,
    input wire logic                       o_input_choice,
    input wire logic                       o_filter_on,
    input wire logic [1:0]                 o_hf_gain,
    input wire logic                       o_output_mute,
    input wire logic [vfc_pkg::ADDR_W-1:0] o_dev_addr,
    input wire logic                       o_addr_locked,
    input wire logic [vfc_pkg::TRIM_W-1:0] o_trim_code,
    input wire logic [vfc_pkg::CTRL_W-1:0] o_channel_control
);
    // ------------------------------------------------------------
    // Fields other than clamp, checked once register and field have both settled; reset value and spare bit are checked without that wait
    // ------------------------------------------------------------
    wire [7:0] cc = o_channel_control;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    reset_value_a: assert property ($rose(i_rst_n) |-> cc == 8'h60)
        else $error("control not at default after reset");
    sync_dir_a: assert property (
        $stable(cc) && $stable(o_sync_pin_oe) |-> o_sync_pin_oe == !cc[7])
        else $error("sync pin direction wrong");
    input_sel_a: assert property (
        $stable(cc) && $stable(o_input_choice) |-> o_input_choice == cc[6])
        else $error("input choice wrong");
    filter_sel_a: assert property (
        $stable(cc) && $stable(o_filter_on) |-> o_filter_on == cc[5])
        else $error("filter path wrong");
    gain_sel_a: assert property (
        $stable(cc) && $stable(o_hf_gain) |-> o_hf_gain == cc[3:2])
        else $error("boost code wrong");
    mute_sel_a: assert property (
        $stable(cc) && $stable(o_output_mute) |-> o_output_mute == cc[1])
        else $error("mute wrong");
    spare_zero_a: assert property (cc[0] == 1'b0)
        else $error("spare bit not zero");
    // Trim may only creep by one code, and not faster than every few cycles
    trim_step_a: assert property (
        $changed(o_trim_code) |-> (o_trim_code == $past(o_trim_code) + 4'h1 ||
        o_trim_code == $past(o_trim_code) - 4'h1) ##1 $stable(o_trim_code)[*8])
        else $error("trim step too large or too soon");
    addr_hold_a: assert property (
        o_addr_locked && $past(o_addr_locked) |-> $stable(o_dev_addr))
        else $error("locked address moved");
endmodule

bind vfc_ctrl vfc_ctrl_chk vfc_ctrl_chk_inst (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .o_sync_pin_oe(o_sync_pin_oe),
    .o_input_choice(o_input_choice), .o_filter_on(o_filter_on), .o_hf_gain(o_hf_gain),
    .o_output_mute(o_output_mute), .o_dev_addr(o_dev_addr), .o_addr_locked(o_addr_locked),
    .o_trim_code(o_trim_code), .o_channel_control(o_channel_control)
);

// [dv/vfc_host_model.sv]
// Bus host model: sends framed writes as active-low pulses on the data line.
// Assumes the line idles high, as with a pull-up, between pulses.
`timescale 1ns/1ps
module vfc_host_model #(
    parameter int ZERO_W  = 400,
    parameter int ONE_W   = 1800,
    parameter int TRANS_W = 2200,
    parameter int GAP_W   = 120
) (
    input  wire logic i_clk,
    output logic      o_data
);
    // ------------------------------------------------------------
    // Pulse and frame generation
    // ------------------------------------------------------------
    initial o_data = 1'b1;

    // Gap after each pulse keeps pulses from merging
    task automatic pulse(input int w);
        @(negedge i_clk);
        o_data = 1'b0;
        repeat (w) @(negedge i_clk);
        o_data = 1'b1;
        repeat (GAP_W) @(negedge i_clk);
    endtask

    task automatic send_frame(input logic b, input logic [3:0] a, input logic [7:0] d);
        logic [12:0] f;
        f = {d, a, b};
        pulse(TRANS_W);
        for (int i = 0; i < 13; i++) begin
            pulse(f[i] ? ONE_W : ZERO_W);
        end
    endtask
endmodule

// [dv/vfc_ctrl_tb_top.sv]
// Self-checking bench for the video filter control register block.
// Assumes the host model drives the bus line; other inputs come from here.
`timescale 1ns/1ps
module vfc_ctrl_tb_top;
    import vfc_pkg::*;
    logic       i_clk, i_rst_n, i_data, i_bias_timing_pin;
    logic       i_sync_pin_i, i_sync_detect, i_trim_high;
    logic       o_sync_pin_o, o_sync_pin_oe, o_sync_ext, o_input_choice, o_filter_on;
    logic       o_clamp_level_select, o_output_mute, o_addr_locked;
    logic [1:0] o_hf_gain;
    logic [3:0] o_dev_addr, o_trim_code;
    logic [7:0] o_channel_control;
    int         n_mismatch = 0;
    int         compares   = 0;

    // Windows shrunk for a short run; zero window is fixed at 200..1600, so one and
    // command sit just above it and stay apart from each other
    vfc_ctrl #(.ONE_MIN_CYC(1700), .ONE_MAX_CYC(1900), .TRANS_MIN_CYC(2000),
        .TRANS_MAX_CYC(2400), .ADDR_SLOT_CYC(50)) vfc_ctrl_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_data(i_data),
        .i_bias_timing_pin(i_bias_timing_pin), .i_sync_pin_i(i_sync_pin_i),
        .i_sync_detect(i_sync_detect), .i_trim_high(i_trim_high),
        .o_sync_pin_o(o_sync_pin_o), .o_sync_pin_oe(o_sync_pin_oe), .o_sync_ext(o_sync_ext),
        .o_input_choice(o_input_choice), .o_filter_on(o_filter_on),
        .o_clamp_level_select(o_clamp_level_select), .o_hf_gain(o_hf_gain),
        .o_output_mute(o_output_mute), .o_dev_addr(o_dev_addr),
        .o_addr_locked(o_addr_locked), .o_trim_code(o_trim_code),
        .o_channel_control(o_channel_control));
    vfc_host_model vfc_host_model_inst (.i_clk(i_clk), .o_data(i_data));

    // ------------------------------------------------------------
    // Checking and bus tasks
    // ------------------------------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic final_report();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_regs(input logic [7:0] e);
        check8("control", {e[7:1], 1'b0}, o_channel_control);
        check8("sync_oe", {7'h00, ~e[7]}, {7'h00, o_sync_pin_oe});
        check8("input", {7'h00, e[6]}, {7'h00, o_input_choice});
        check8("filter", {7'h00, e[5]}, {7'h00, o_filter_on});
        check8("clamp", {7'h00, e[4]}, {7'h00, o_clamp_level_select});
        check8("gain", {6'h00, e[3:2]}, {6'h00, o_hf_gain});
        check8("mute", {7'h00, e[1]}, {7'h00, o_output_mute});
    endtask

    // Outputs settle a few cycles after the last bit; eight is ample
    task automatic write_frame(input logic b, input logic [3:0] a, input logic [7:0] d,
                               input logic [7:0] e);
        vfc_host_model_inst.send_frame(b, a, d);
        repeat (8) @(negedge i_clk);
        check_regs(e);
    endtask

    task automatic wait_lock();
        for (int n = 0; n < 50; n++) begin
            if (o_addr_locked === 1'b1) return;
            @(negedge i_clk);
        end
        n_mismatch++;
        $display("CHECK FAILED addr_locked expected 1 seen %b", o_addr_locked);
        final_report();
    endtask

    initial begin
        i_rst_n = 1'b0;
        i_bias_timing_pin = 1'b0;
        i_sync_pin_i = 1'b0;
        i_sync_detect = 1'b0;
        i_trim_high = 1'b1;
        repeat (6) @(negedge i_clk);
        i_rst_n = 1'b1;
        check_regs(8'h60);
        // Bias pin low for three and a half slots, then charged
        repeat (175) @(negedge i_clk);
        i_bias_timing_pin = 1'b1;
        wait_lock();
        check8("dev_addr", 8'h03, {4'h0, o_dev_addr});
        i_sync_detect = 1'b1;
        repeat (5) @(negedge i_clk);
        check8("sync_out", 8'h01, {7'h00, o_sync_pin_o});
        write_frame(1'b1, 4'h0, 8'h8F, 8'h8E);
        i_sync_pin_i = 1'b1;
        repeat (5) @(negedge i_clk);
        check8("sync_ext", 8'h01, {7'h00, o_sync_ext});
        write_frame(1'b0, 4'h3, 8'h08, 8'h08);
        check8("sync_ext", 8'h00, {7'h00, o_sync_ext});
        check8("sync_out", 8'h01, {7'h00, o_sync_pin_o});
        write_frame(1'b0, 4'h5, 8'hFF, 8'h08);
        write_frame(1'b1, 4'h0, 8'h74, 8'h74);
        check8("trim", 8'h00, {4'h0, o_trim_code});
        // Low pulse longer than any command: soft reset, address re-taken at once
        vfc_host_model_inst.pulse(2600);
        repeat (8) @(negedge i_clk);
        check_regs(8'h60);
        check8("dev_addr", 8'h00, {4'h0, o_dev_addr});
        check8("addr_locked", 8'h01, {7'h00, o_addr_locked});
        final_report();
    end
endmodule
